// ### hdl/cidrx_regs.sv
// Contract
// R01: event register at 00H, fixed bit layout
// R02: minute and second ticks set event bits
// R03: received byte sets bit 5 if enabled
// R04: bit 4 follows low level, no irq
// R05: falling edge on polarity b sets bit 3
// R06: rising edge on polarity a sets bit 2
// R07: alert tone detection sets bit 1
// R08: received byte readable at 01H
// R09: status bits 7,6 show live polarity
// R10: status bit 5 shows weak battery
// R11: status bit 4 shows mark start seen
// R12: status bit 3 flags overrun
// R13: status bit 2 flags framing error
// R14: ring period count between polarity b rises
// R15: cfg1 bit 7 enables fsk receiver
// R16: cfg1 bit 6 waits for mark before events
// R17: cfg1 bit 5 enables tone detector
// R18: cfg1 bit 4 enables polarity events
// R19: cfg1 bit 3 selects irq polarity
// R20: cfg2 bit 7 enables fast oscillator
// R21: cfg2 bits 6,5 timebase enable and period
// R22: cfg2 bit 4 suppresses ticks during fsk
// R23: writes to read-only offsets change nothing
// R24: unmapped reads return FFH
// R25: suppressed ticks still latch their flags
// R26: irq asserted while enabled event pending
// R27: event flags clear on register read
`timescale 1ns/1ps
`default_nettype none
module cidrx_regs
  import cidrx_pkg::*;
#(
  parameter int TICKS_PER_SEC = CIDRX_TICKS_PER_SEC
) (
  // system clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // slow timebase clock
  input wire logic i_slow_clk,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // receiver and detector events
  input wire logic i_fsk_byte_stb,
  input wire logic [7:0] i_fsk_byte,
  input wire logic i_fsk_framing_err,
  input wire logic i_fsk_mark_seen,
  input wire logic i_fsk_active,
  input wire logic i_tone_stb,
  // comparator pins
  input wire logic i_line_polarity_a_input,
  input wire logic i_line_polarity_b_input,
  input wire logic i_battery_monitor_input,
  input wire logic i_low_level_input,
  // enables and irq
  output logic o_fsk_receiver_en,
  output logic o_tone_det_en,
  output logic o_fast_osc_en,
  output logic o_irq
);

  logic [7:0] cfg1_r;
  logic [7:0] cfg2_r;
  logic [7:0] event_r;
  logic [7:0] fsk_byte_r;
  logic fsk_unread_r;
  logic rx_overrun_flag_r;
  logic rx_framing_flag_r;
  logic [7:0] ring_cnt_r;
  logic [7:0] ring_period_r;
  logic ring_armed_r;
  logic [2:0] pa_sync_r;
  logic [2:0] pb_sync_r;
  logic [1:0] bat_sync_r;
  logic [1:0] lvl_sync_r;
  logic [1:0] mark_sync_r;
  logic [1:0] act_sync_r;

  // one decoder for every strobe and offset pair
  function automatic logic reg_hit(input logic stb, input logic [7:0] addr, input logic [7:0] ofs);
    return stb && (addr == ofs);
  endfunction

  wire logic rd_event = reg_hit(i_reg_rd, i_reg_addr, CIDRX_OFS_EVENT);
  wire logic rd_fskb = reg_hit(i_reg_rd, i_reg_addr, CIDRX_OFS_FSKB);
  wire logic fsk_en = cfg1_r[CIDRX_C1_FSK_EN];
  wire logic pol_en = cfg1_r[CIDRX_C1_POL_EN];
  wire logic polb_s = pb_sync_r[1];
  wire logic pola_s = pa_sync_r[1];
  wire logic polb_fall = pb_sync_r[2] && !pb_sync_r[1];
  wire logic polb_rise = !pb_sync_r[2] && pb_sync_r[1];
  wire logic pola_rise = !pa_sync_r[2] && pa_sync_r[1];

  // pin synchronisers; stage 2 kept separate for edge detection
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pa_sync_r <= 3'h0;
      pb_sync_r <= 3'h0;
      bat_sync_r <= 2'h0;
      lvl_sync_r <= 2'h0;
      mark_sync_r <= 2'h0;
      act_sync_r <= 2'h0;
    end else begin
      pa_sync_r <= {pa_sync_r[1:0], i_line_polarity_a_input};
      pb_sync_r <= {pb_sync_r[1:0], i_line_polarity_b_input};
      bat_sync_r <= {bat_sync_r[0], i_battery_monitor_input};
      lvl_sync_r <= {lvl_sync_r[0], i_low_level_input};
      mark_sync_r <= {mark_sync_r[0], i_fsk_mark_seen};
      act_sync_r <= {act_sync_r[0], i_fsk_active};
    end
  end

  // timebase in the slow domain; the tick crosses as a toggle
  logic [15:0] slow_sub_r;
  logic [5:0] slow_sec_r;
  logic sec_tgl_r;
  logic min_tgl_r;
  logic [1:0] en_sync_slow_r;
  logic [1:0] sel_sync_slow_r;
  wire logic slow_sec_wrap = (slow_sub_r == 16'(TICKS_PER_SEC - 1));
  wire logic slow_min_wrap = slow_sec_wrap && (slow_sec_r == 6'(CIDRX_SEC_PER_MIN - 1));

  always_ff @(posedge i_slow_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      en_sync_slow_r <= 2'h0;
      sel_sync_slow_r <= 2'h0;
    end else begin
      en_sync_slow_r <= {en_sync_slow_r[0], cfg2_r[CIDRX_C2_TICK_EN]};
      sel_sync_slow_r <= {sel_sync_slow_r[0], cfg2_r[CIDRX_C2_SEC_SEL]};
    end
  end

  // R21: timebase enable and period
  always_ff @(posedge i_slow_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      slow_sub_r <= 16'h0;
      slow_sec_r <= 6'h0;
      sec_tgl_r <= 1'b0;
      min_tgl_r <= 1'b0;
    end else if (!en_sync_slow_r[1]) begin
      slow_sub_r <= 16'h0;
      slow_sec_r <= 6'h0;
    end else begin
      slow_sub_r <= slow_sec_wrap ? 16'h0 : slow_sub_r + 16'h1;
      if (slow_sec_wrap) begin
        slow_sec_r <= slow_min_wrap ? 6'h0 : slow_sec_r + 6'h1;
      end
      // separate toggles: a shared kind bit could be caught mid-change
      if (sel_sync_slow_r[1] && slow_sec_wrap) begin
        sec_tgl_r <= !sec_tgl_r;
      end
      if (!sel_sync_slow_r[1] && slow_min_wrap) begin
        min_tgl_r <= !min_tgl_r;
      end
    end
  end

  // toggles back in the system domain; a change past stage 2 is one tick
  logic [2:0] sec_sync_r;
  logic [2:0] min_sync_r;
  wire logic sec_evt = sec_sync_r[2] ^ sec_sync_r[1];
  wire logic min_evt = min_sync_r[2] ^ min_sync_r[1];
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sec_sync_r <= 3'h0;
      min_sync_r <= 3'h0;
    end else begin
      sec_sync_r <= {sec_sync_r[1:0], sec_tgl_r};
      min_sync_r <= {min_sync_r[1:0], min_tgl_r};
    end
  end

  // R15 R16: byte event gated by enable and mark wait
  wire logic fsk_evt = i_fsk_byte_stb && fsk_en &&
                       (!cfg1_r[CIDRX_C1_WAIT_MARK] || mark_sync_r[1]);

  // R01 R02 R05 R06: what sets each event bit
  logic [7:0] ev_set;
  always_comb begin
    ev_set = 8'h00;
    ev_set[CIDRX_EV_MIN] = min_evt;
    ev_set[CIDRX_EV_SEC] = sec_evt;
    // R03: byte event
    ev_set[CIDRX_EV_FSK] = fsk_evt;
    ev_set[CIDRX_EV_POLB] = polb_fall;
    ev_set[CIDRX_EV_POLA] = pola_rise;
    // R07: alert tone
    ev_set[CIDRX_EV_TONE] = i_tone_stb;
  end

  // R17 R18: enables hold a bit at zero; low level and bit 0 never latch
  logic [7:0] ev_keep;
  always_comb begin
    ev_keep = 8'h00;
    // R25: ticks latch even when irq suppressed
    ev_keep[CIDRX_EV_MIN] = 1'b1;
    ev_keep[CIDRX_EV_SEC] = 1'b1;
    ev_keep[CIDRX_EV_FSK] = fsk_en;
    ev_keep[CIDRX_EV_POLB] = pol_en;
    ev_keep[CIDRX_EV_POLA] = pol_en;
    ev_keep[CIDRX_EV_TONE] = cfg1_r[CIDRX_C1_TONE_EN];
  end

  // R27: read of 00H clears, a set in the same cycle wins
  logic [7:0] event_nxt;
  for (genvar b = 0; b < 8; b++) begin : g_event
    assign event_nxt[b] = ev_keep[b] && (ev_set[b] || (event_r[b] && !rd_event));
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      event_r <= 8'h00;
    end else begin
      event_r <= event_nxt;
    end
  end

  // R08: accepted byte held until the next one
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fsk_byte_r <= 8'h00;
    end else if (fsk_evt) begin
      fsk_byte_r <= i_fsk_byte;
    end
  end

  // unread marker feeds the overrun check
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fsk_unread_r <= 1'b0;
    end else if (fsk_evt) begin
      fsk_unread_r <= 1'b1;
    end else if (rd_fskb) begin
      fsk_unread_r <= 1'b0;
    end
  end

  // R12: overrun; a new byte and a clearing read in the same cycle leave the flag unchanged
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_overrun_flag_r <= 1'b0;
    end else if (fsk_evt && fsk_unread_r && !rd_fskb) begin
      rx_overrun_flag_r <= 1'b1;
    end else if (rd_fskb && !fsk_evt) begin
      rx_overrun_flag_r <= 1'b0;
    end
  end

  // R13: framing follows each accepted byte
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_framing_flag_r <= 1'b0;
    end else if (fsk_evt) begin
      rx_framing_flag_r <= i_fsk_framing_err;
    end
  end

  // R14: cycle count since the last polarity b rise, held at FFH
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ring_cnt_r <= 8'h00;
    end else if (polb_rise) begin
      ring_cnt_r <= 8'h00;
    end else if (ring_cnt_r != 8'hFF) begin
      ring_cnt_r <= ring_cnt_r + 8'h1;
    end
  end

  // R14: a polarity a rise arms the next capture
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ring_armed_r <= 1'b0;
    end else if (polb_rise) begin
      ring_armed_r <= 1'b0;
    end else if (pola_rise) begin
      ring_armed_r <= 1'b1;
    end
  end

  // R14: capture only when armed; the count unit is the system clock
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ring_period_r <= 8'h00;
    end else if (polb_rise && ring_armed_r) begin
      ring_period_r <= ring_cnt_r;
    end
  end

  // R23: only the two config offsets accept writes
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg1_r <= CIDRX_CFG1_RST;
    end else if (reg_hit(i_reg_wr, i_reg_addr, CIDRX_OFS_CFG1)) begin
      // reserved bits always read back as zero
      cfg1_r <= i_reg_wdata & CIDRX_C1_MASK;
    end
  end

  // R23: second config register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg2_r <= CIDRX_CFG2_RST;
    end else if (reg_hit(i_reg_wr, i_reg_addr, CIDRX_OFS_CFG2)) begin
      cfg2_r <= i_reg_wdata & CIDRX_C2_MASK;
    end
  end

  // R09 R10 R11 R12 R13: live status byte, bits 1 and 0 reserved
  logic [7:0] status_nxt;
  always_comb begin
    status_nxt = 8'h00;
    status_nxt[CIDRX_ST_POLB] = polb_s;
    status_nxt[CIDRX_ST_POLA_LOW] = !pola_s;
    status_nxt[CIDRX_ST_BAT] = bat_sync_r[1];
    status_nxt[CIDRX_ST_MARK] = mark_sync_r[1];
    status_nxt[CIDRX_ST_OVR] = rx_overrun_flag_r;
    status_nxt[CIDRX_ST_FRM] = rx_framing_flag_r;
  end

  // read mux; R04: low level is live and outside the irq
  logic [7:0] rdata_nxt;
  always_comb begin
    rdata_nxt = CIDRX_UNMAPPED;
    case (i_reg_addr)
      CIDRX_OFS_EVENT: begin
        rdata_nxt = event_r;
        rdata_nxt[CIDRX_EV_LOWLVL] = lvl_sync_r[1];
      end
      CIDRX_OFS_FSKB: rdata_nxt = fsk_byte_r;
      CIDRX_OFS_STAT: rdata_nxt = status_nxt;
      CIDRX_OFS_RING: rdata_nxt = ring_period_r;
      CIDRX_OFS_CFG1: rdata_nxt = cfg1_r;
      CIDRX_OFS_CFG2: rdata_nxt = cfg2_r;
      // R24: unmapped reads all ones
      default: rdata_nxt = CIDRX_UNMAPPED;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= rdata_nxt;
    end
  end

  // R22 R25 R26: irq from pending events, ticks masked during reception
  wire logic supp = cfg2_r[CIDRX_C2_SUPP] && act_sync_r[1];
  // R04: low level status is left out of the request
  wire logic ev_pend = event_r[CIDRX_EV_FSK] || event_r[CIDRX_EV_POLB] ||
                       event_r[CIDRX_EV_POLA] || event_r[CIDRX_EV_TONE];
  wire logic tick_pend = event_r[CIDRX_EV_MIN] || event_r[CIDRX_EV_SEC];
  wire logic pend = ev_pend || (tick_pend && !supp);
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq <= 1'b1;
    end else begin
      // R19: polarity select
      o_irq <= cfg1_r[CIDRX_C1_IRQ_HIGH] ? pend : !pend;
    end
  end

  // R20 R15 R17: enables out to the analog side
  assign o_fast_osc_en = cfg2_r[CIDRX_C2_OSC_EN];
  assign o_fsk_receiver_en = fsk_en;
  assign o_tone_det_en = cfg1_r[CIDRX_C1_TONE_EN];

endmodule
`default_nettype wire

// ### hdl/cidrx_pkg.sv
package cidrx_pkg;
  // register offsets
  localparam logic [7:0] CIDRX_OFS_EVENT = 8'h00;
  localparam logic [7:0] CIDRX_OFS_FSKB = 8'h01;
  localparam logic [7:0] CIDRX_OFS_STAT = 8'h02;
  localparam logic [7:0] CIDRX_OFS_RING = 8'h03;
  localparam logic [7:0] CIDRX_OFS_CFG1 = 8'h04;
  localparam logic [7:0] CIDRX_OFS_CFG2 = 8'h05;
  localparam logic [7:0] CIDRX_UNMAPPED = 8'hFF;
  // reset values
  localparam logic [7:0] CIDRX_CFG1_RST = 8'h58;
  localparam logic [7:0] CIDRX_CFG2_RST = 8'hD0;
  // event_flags bit positions
  localparam int CIDRX_EV_MIN = 7;
  localparam int CIDRX_EV_SEC = 6;
  localparam int CIDRX_EV_FSK = 5;
  localparam int CIDRX_EV_LOWLVL = 4;
  localparam int CIDRX_EV_POLB = 3;
  localparam int CIDRX_EV_POLA = 2;
  localparam int CIDRX_EV_TONE = 1;
  // function_enable_cfg bit positions
  localparam int CIDRX_C1_FSK_EN = 7;
  localparam int CIDRX_C1_WAIT_MARK = 6;
  localparam int CIDRX_C1_TONE_EN = 5;
  localparam int CIDRX_C1_POL_EN = 4;
  localparam int CIDRX_C1_IRQ_HIGH = 3;
  localparam logic [7:0] CIDRX_C1_MASK = 8'hF8;
  // clock_timebase_cfg bit positions
  localparam int CIDRX_C2_OSC_EN = 7;
  localparam int CIDRX_C2_TICK_EN = 6;
  localparam int CIDRX_C2_SEC_SEL = 5;
  localparam int CIDRX_C2_SUPP = 4;
  localparam logic [7:0] CIDRX_C2_MASK = 8'hF0;
  // line_status bit positions
  localparam int CIDRX_ST_POLB = 7;
  localparam int CIDRX_ST_POLA_LOW = 6;
  localparam int CIDRX_ST_BAT = 5;
  localparam int CIDRX_ST_MARK = 4;
  localparam int CIDRX_ST_OVR = 3;
  localparam int CIDRX_ST_FRM = 2;
  // timebase on the slow link clock
  localparam int CIDRX_SLOW_HZ = 32768;
  localparam int CIDRX_TICKS_PER_SEC = CIDRX_SLOW_HZ;
  localparam int CIDRX_SEC_PER_MIN = 60;
endpackage

// ### tb/cidrx_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cidrx_regs_chk
  import cidrx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_tone_stb,
  input wire logic o_fsk_receiver_en,
  input wire logic o_tone_det_en,
  input wire logic o_fast_osc_en
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic wr1;
  logic wr2;
  assign wr1 = i_reg_wr && i_reg_addr == CIDRX_OFS_CFG1;
  assign wr2 = i_reg_wr && i_reg_addr == CIDRX_OFS_CFG2;
  AST_FSK_EN: assert property (wr1 |=> o_fsk_receiver_en == $past(i_reg_wdata[7])) else $error("fsk enable wrong");
  AST_TONE_EN: assert property (wr1 |=> o_tone_det_en == $past(i_reg_wdata[5])) else $error("tone enable wrong");
  AST_OSC_EN: assert property (wr2 |=> o_fast_osc_en == $past(i_reg_wdata[7])) else $error("osc enable wrong");
  AST_RO_WR: assert property (i_reg_wr && i_reg_addr < 8'h04 |=> $stable({o_fsk_receiver_en, o_tone_det_en, o_fast_osc_en}))
    else $error("read-only write changed state");
  AST_UNMAPPED: assert property (i_reg_addr > 8'h05 |=> o_reg_rdata == 8'hFF) else $error("unmapped read not all ones");
  AST_CFG_RB: assert property (wr1 ##1 (!i_reg_wr && i_reg_addr == CIDRX_OFS_CFG1) |=>
    o_reg_rdata == ($past(i_reg_wdata, 2) & CIDRX_C1_MASK)) else $error("cfg1 readback wrong");
  AST_TONE_SET: assert property (i_tone_stb && o_tone_det_en ##1 (i_reg_addr == 8'h00 && !i_reg_rd)[*2] |=>
    o_reg_rdata[CIDRX_EV_TONE]) else $error("tone event missing");
  AST_READ_CLR: assert property (i_reg_rd && i_reg_addr == 8'h00 && !i_tone_stb ##1 (i_reg_addr == 8'h00 && !i_tone_stb)[*2]
    |=> !o_reg_rdata[CIDRX_EV_TONE]) else $error("tone event not cleared");
  COV_TONE: cover property (i_tone_stb && o_tone_det_en);
  COV_UNMAP: cover property (i_reg_addr > 8'h05);
  COV_CFG: cover property (wr2);
endmodule
bind cidrx_regs cidrx_regs_chk chk (.i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata,
  .i_tone_stb, .o_fsk_receiver_en, .o_tone_det_en, .o_fast_osc_en);
`default_nettype wire

// ### tb/cidrx_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cidrx_host_model (
  // clock and read data
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  // register port
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    // released data is inverted so a stale byte never looks valid
    o_wdata = ~d;
  endtask
  // c selects a clearing read; data taken once the edge has landed
  task automatic rd(input logic [7:0] a, input logic c, output logic [7:0] q);
    @(negedge i_clk);
    o_addr = a;
    o_rd = c;
    @(negedge i_clk);
    o_rd = 1'b0;
    q = i_rdata;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cidrx_pkg::*;
  logic clk = 1'b0, slow = 1'b0, rst = 1'b1, fstb = 1'b0, ferr = 1'b0, mark = 1'b0, act = 1'b0, tone = 1'b0;
  logic pa = 1'b0, pb = 1'b0, bat = 1'b0, lowl = 1'b0, wr, rd, en_f, en_t, en_o, irq;
  logic [7:0] fbyte = 8'h00, addr, wd, rdat, q, d, a;
  int err_total = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  initial begin
    #3;
    forever #15 slow = ~slow;
  end
  cidrx_regs #(.TICKS_PER_SEC(4)) dut (.i_clk(clk), .i_sys_rst(rst), .i_slow_clk(slow), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_fsk_byte_stb(fstb), .i_fsk_byte(fbyte),
    .i_fsk_framing_err(ferr), .i_fsk_mark_seen(mark), .i_fsk_active(act), .i_tone_stb(tone),
    .i_line_polarity_a_input(pa), .i_line_polarity_b_input(pb), .i_battery_monitor_input(bat),
    .i_low_level_input(lowl), .o_fsk_receiver_en(en_f), .o_tone_det_en(en_t), .o_fast_osc_en(en_o), .o_irq(irq));
  cidrx_host_model host (.i_clk(clk), .i_rdata(rdat), .o_addr(addr), .o_wr(wr), .o_wdata(wd), .o_rd(rd));
  function automatic logic [7:0] cfg_exp(input logic [7:0] ra, input logic [7:0] v);
    return v & (ra == CIDRX_OFS_CFG2 ? CIDRX_C2_MASK : CIDRX_C1_MASK);
  endfunction
  // ring period seen for a gap of so many cycles between polarity b rises
  function automatic logic [7:0] ring_exp(input int gap);
    return 8'(gap - 1);
  endfunction
  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rdc(input logic [7:0] ra, input logic c, input logic [7:0] m, input logic [7:0] e);
    host.rd(ra, c, q);
    chk8(e, q & m);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    #100000;
    err_total++;
    test_done();
  end
  initial begin
    void'($urandom(32'h78EA64FE));
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    rdc(CIDRX_OFS_CFG1, 1'b0, 8'hFF, CIDRX_CFG1_RST); // reset value
    rdc(CIDRX_OFS_CFG2, 1'b0, 8'hFF, CIDRX_CFG2_RST); // reset value
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'hEE, 8'h00); // reset value
    for (int i = 0; i < 8; i++) begin
      a = i[0] ? CIDRX_OFS_CFG2 : CIDRX_OFS_CFG1;
      d = 8'($urandom);
      host.wr(a, d);
      rdc(a, 1'b0, 8'hFF, cfg_exp(a, d)); // readback
      chk8({7'h00, d[7]}, {7'h00, i[0] ? en_o : en_f}); // enables
      if (!i[0]) chk8({7'h00, d[5]}, {7'h00, en_t}); // enable
    end
    host.wr(CIDRX_OFS_CFG2, 8'h80);
    host.wr(CIDRX_OFS_CFG1, 8'h28);
    for (int i = 0; i < 6; i++) begin
      a = i < 4 ? 8'(i) : 8'h06 + 8'($urandom_range(249));
      host.wr(a, 8'h00);
      rdc(CIDRX_OFS_CFG1, 1'b0, 8'hFF, 8'h28); // unchanged
      if (i > 3) rdc(a, 1'b0, 8'hFF, 8'hFF); // all ones
    end
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h00, 8'h00);
    pulse(tone);
    idle(2);
    chk8(8'h01, {7'h00, irq}); // asserted
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'hEE, 8'h02); // tone
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'hEE, 8'h00); // cleared
    chk8(8'h00, {7'h00, irq}); // released
    host.wr(CIDRX_OFS_CFG1, 8'h20);
    idle(2);
    chk8(8'h01, {7'h00, irq}); // low idle
    pulse(tone);
    idle(2);
    chk8(8'h00, {7'h00, irq}); // active low
    host.wr(CIDRX_OFS_CFG1, 8'h08);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h00, 8'h00);
    pulse(tone);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h02, 8'h00); // disabled
    host.wr(CIDRX_OFS_CFG1, 8'h88);
    d = 8'($urandom);
    fbyte = d;
    pulse(fstb);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h20, 8'h20); // byte event
    rdc(CIDRX_OFS_STAT, 1'b0, 8'h0C, 8'h00); // no error
    rdc(CIDRX_OFS_FSKB, 1'b1, 8'hFF, d); // valid byte
    ferr = 1'b1;
    pulse(fstb);
    ferr = 1'b0;
    rdc(CIDRX_OFS_STAT, 1'b0, 8'h04, 8'h04); // framing
    pulse(fstb);
    rdc(CIDRX_OFS_STAT, 1'b0, 8'h08, 8'h08); // overrun
    rdc(CIDRX_OFS_FSKB, 1'b1, 8'h00, 8'h00);
    mark = 1'b1;
    idle(4);
    rdc(CIDRX_OFS_STAT, 1'b0, 8'h10, 8'h10); // mark seen
    mark = 1'b0;
    host.wr(CIDRX_OFS_CFG1, 8'hC8);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h00, 8'h00);
    idle(4);
    pulse(fstb);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h20, 8'h00); // masked
    mark = 1'b1;
    idle(4);
    pulse(fstb);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h20, 8'h20); // after mark
    host.wr(CIDRX_OFS_CFG1, 8'h48);
    pulse(fstb);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h20, 8'h00); // receiver off
    host.wr(CIDRX_OFS_CFG1, 8'h08);
    host.wr(CIDRX_OFS_CFG2, 8'h60);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h00, 8'h00);
    idle(40);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'hC0, 8'h40); // second tick
    act = 1'b1;
    host.wr(CIDRX_OFS_CFG2, 8'h70);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h00, 8'h00);
    idle(40);
    chk8(8'h00, {7'h00, irq}); // suppressed
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h40, 8'h40); // still latched
    act = 1'b0;
    idle(40);
    chk8(8'h01, {7'h00, irq}); // allowed
    host.wr(CIDRX_OFS_CFG2, 8'h40);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h00, 8'h00);
    idle(800);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h80, 8'h80); // minute tick
    host.wr(CIDRX_OFS_CFG2, 8'h80);
    host.wr(CIDRX_OFS_CFG1, 8'h18);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h00, 8'h00);
    pa = 1'b1;
    idle(6);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h0C, 8'h04); // rise a
    pb = 1'b1;
    idle(6);
    pb = 1'b0;
    idle(6);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h0C, 8'h08); // fall b
    host.wr(CIDRX_OFS_CFG1, 8'h08);
    pa = 1'b0;
    idle(6);
    pa = 1'b1;
    idle(6);
    rdc(CIDRX_OFS_EVENT, 1'b1, 8'h0C, 8'h00); // disabled
    d = 8'($urandom_range(200, 20));
    pb = 1'b1;
    idle(2);
    pb = 1'b0;
    pa = 1'b0;
    idle(2);
    pa = 1'b1;
    idle(int'(d));
    pb = 1'b1;
    idle(6);
    rdc(CIDRX_OFS_RING, 1'b0, 8'hFF, ring_exp(int'(d) + 4)); // period
    pb = 1'b0;
    idle(6);
    pb = 1'b1;
    idle(6);
    rdc(CIDRX_OFS_RING, 1'b0, 8'hFF, ring_exp(int'(d) + 4)); // needs a rise
    rdc(CIDRX_OFS_STAT, 1'b0, 8'hC0, 8'h80); // live polarity
    pa = 1'b0;
    pb = 1'b0;
    bat = 1'b1;
    idle(6);
    rdc(CIDRX_OFS_STAT, 1'b0, 8'hE0, 8'h60); // weak battery
    lowl = 1'b1;
    idle(6);
    rdc(CIDRX_OFS_EVENT, 1'b0, 8'h10, 8'h10); // low level
    chk8(8'h00, {7'h00, irq}); // no request
    test_done();
  end
endmodule
`default_nettype wire
